//--- core/lstff_pkg.sv
`default_nettype none
package lstff_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_INFO     = 8'h0e;
  localparam logic [7:0] REG_ERR0     = 8'h11;
  localparam logic [7:0] REG_ERR1     = 8'h12;
  localparam logic [7:0] REG_MASK     = 8'h13;
  localparam logic [7:0] REG_SELFTEST = 8'h87;
  localparam logic [7:0] REG_PINMODE  = 8'h9e;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_START  = 0;
  localparam int BIT_DONE   = 1;
  localparam int BIT_PASS   = 2;
  localparam int BIT_MANCH  = 15;
  localparam int INFO_ANGLE = 0;
  localparam int INFO_TURN  = 1;
  localparam int INFO_COUNT = 2;
  localparam int INFO_ENC   = 3;
  localparam int INFO_EDGE  = 4;
  localparam int INFO_SLEEP = 6;
  localparam int MASK_ENC   = 16;
  localparam int MASK_EDGE  = 17;
  // ---------------------------------------------------------------
  // serial frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int FRAME_WR   = 31;
  localparam int ADDR_LSB   = 23;
  localparam int DATA_W     = 23;
  localparam int RSP_DATA_W = 22;
  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int ERR_W  = 16;
  localparam int MASK_W = 18;
  localparam int SIG_W  = 31;
  localparam int SCAN_CHAINS = 31;
  localparam int CHAIN_LEN_DEF = 8;
  localparam logic [MASK_W-1:0] MASK_RST  = 18'h00000;
  localparam logic [SIG_W-1:0]  LFSR_SEED = 31'h00000001;
  localparam logic [SIG_W-1:0]  SIGNATURE_COMPACTOR_SEED = 31'h00000000;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ      = 20_000_000;
  localparam int SELFTEST_MS     = 105;
  localparam int SELFTEST_CYCLES = SELFTEST_MS * (SYS_CLK_HZ / 1000);
  localparam int POST_RST_CYCLES = 16;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_POSTRST} lstff_state_t;
endpackage
`default_nettype wire

//--- core/lstff_top.sv
`timescale 1ns/1ns
`default_nettype none
module lstff_top
  import lstff_pkg::*;
#(
  parameter int SELFTEST_CYC = SELFTEST_CYCLES,
  parameter int CHAIN_LEN    = CHAIN_LEN_DEF
)(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             spi_sclk,
  input  wire logic             spi_cs_n,
  input  wire logic             spi_mosi,
  output logic                  spi_miso,
  output logic                  spi_miso_oe,
  input  wire logic [ERR_W-1:0] err_cond,
  input  wire logic             angle_valid_flag,
  input  wire logic             turn_direction_flag,
  input  wire logic             encoder_countup_done,
  input  wire logic             encoder_integrity_fault,
  input  wire logic             edge_rate_warning,
  input  wire logic             sleep_exit,
  input  wire logic             access_code_hit,
  input  wire logic             scan_fault_inject,
  input  wire logic             pwm_level,
  input  wire logic             manch_tx_data,
  input  wire logic             manch_tx_oe,
  input  wire logic             pwm_pin_in,
  output logic                  pwm_pin_out,
  output logic                  pwm_pin_oe,
  output logic                  manch_rx,
  output logic                  pin_serial_mode_enable,
  output logic                  normal_op_hold,
  output logic                  full_rst_req,
  output logic                  frame_fault_summary_a,
  output logic                  frame_fault_summary_b
);
  if (CHAIN_LEN < 2 || SELFTEST_CYC <= CHAIN_LEN)
    $error("lstff_top: chain length or test length out of range");

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sclk_s;
  logic [2:0] cs_s;
  logic [1:0] mosi_s;
  logic [1:0] pin_s;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_s <= 3'h0;
      cs_s   <= 3'h7;
      mosi_s <= 2'h0;
      pin_s  <= 2'h0;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], spi_sclk};
      cs_s   <= {cs_s[1:0], spi_cs_n};
      mosi_s <= {mosi_s[0], spi_mosi};
      pin_s  <= {pin_s[0], pwm_pin_in};
    end
  end
  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire sclk_fall = ~sclk_s[1] & sclk_s[2];
  wire cs_fall   = ~cs_s[1] & cs_s[2];
  wire cs_rise   = cs_s[1] & ~cs_s[2];
  wire cs_act    = ~cs_s[1];

  // ---------------------------------------------------------------
  // self-test sequencer
  // ---------------------------------------------------------------
  lstff_state_t state;
  lstff_state_t next_state;
  logic [31:0]  cnt;
  logic         start_req;
  logic         done;
  logic         pass;
  logic [SIG_W-1:0] lfsr;
  logic [SIG_W-1:0] signature_compactor_a;
  logic [SIG_W-1:0] signature_compactor_b;
  wire busy     = (state != ST_IDLE);
  wire run      = (state == ST_RUN);
  wire post     = (state == ST_POSTRST);
  wire run_last = run && (cnt == 32'(SELFTEST_CYC - 1));
  wire post_end = post && (cnt == 32'(POST_RST_CYCLES - 1));
  wire sig_match = (signature_compactor_a == signature_compactor_b);
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:    if (start_req) next_state = ST_RUN;
      ST_RUN:     if (run_last) next_state = ST_POSTRST;
      ST_POSTRST: if (post_end) next_state = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // serial frame engine
  // ---------------------------------------------------------------
  logic [5:0]            bit_cnt;
  logic [FRAME_BITS-1:0] rx_sh;
  logic [FRAME_BITS-1:0] tx_sh;
  logic [7:0]            rsp_addr;
  logic [DATA_W-1:0]     rsp_data;
  wire frame_done = cs_rise && !busy && (bit_cnt == 6'(FRAME_BITS));
  wire [7:0] f_addr = rx_sh[FRAME_WR-1:ADDR_LSB];
  wire [DATA_W-1:0] f_data = rx_sh[DATA_W-1:0];
  wire f_wr     = rx_sh[FRAME_WR];
  wire rd_frame = frame_done && !f_wr;
  wire wr_frame = frame_done && f_wr;
  wire rd_info  = rd_frame && (f_addr == REG_INFO);
  wire rd_err0  = rd_frame && (f_addr == REG_ERR0);
  wire rd_err1  = rd_frame && (f_addr == REG_ERR1);
  wire wr_mask  = wr_frame && (f_addr == REG_MASK);
  wire wr_pin   = wr_frame && (f_addr == REG_PINMODE);
  wire wr_start = wr_frame && (f_addr == REG_SELFTEST)
                  && f_data[BIT_START];
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt     <= 6'h00;
      rx_sh       <= 32'h00000000;
      tx_sh       <= 32'h00000000;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end
    else if (busy || !cs_act)
    begin
      bit_cnt     <= 6'h00;
      spi_miso_oe <= 1'b0;
      spi_miso    <= 1'b0;
    end
    else
    begin
      spi_miso_oe <= 1'b1;
      if (cs_fall)
      begin
        tx_sh    <= {frame_fault_summary_a, frame_fault_summary_b,
                     rsp_addr, rsp_data[RSP_DATA_W-1:0]};
        spi_miso <= frame_fault_summary_a;
      end
      else if (sclk_fall)
      begin
        tx_sh    <= {tx_sh[FRAME_BITS-2:0], 1'b0};
        spi_miso <= tx_sh[FRAME_BITS-2];
      end
      if (sclk_rise)
      begin
        rx_sh <= {rx_sh[FRAME_BITS-2:0], mosi_s[1]};
        if (bit_cnt != 6'h3f)
          bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // flags and summaries
  // ---------------------------------------------------------------
  logic [ERR_W-1:0]  err0;
  logic [ERR_W-1:0]  err1;
  logic [MASK_W-1:0] mask;
  logic              sleep_flag;
  wire [6:0] info = {sleep_flag, 1'b0, edge_rate_warning,
                     encoder_integrity_fault, encoder_countup_done,
                     turn_direction_flag, angle_valid_flag};
  wire cond_a = |(err0 & ~mask[ERR_W-1:0]);
  wire enc_b  = (encoder_integrity_fault & ~mask[MASK_ENC])
              | (edge_rate_warning & ~mask[MASK_EDGE]);
  wire cond_b = |(err1 & ~mask[ERR_W-1:0]) | enc_b;
  wire force_sum = sleep_exit || post;
  wire [DATA_W-1:0] rd_mux =
      (f_addr == REG_INFO)     ? DATA_W'(info) :
      (f_addr == REG_ERR0)     ? DATA_W'(err0) :
      (f_addr == REG_ERR1)     ? DATA_W'(err1) :
      (f_addr == REG_MASK)     ? DATA_W'(mask) :
      (f_addr == REG_SELFTEST) ? DATA_W'({pass, done, start_req}) :
      (f_addr == REG_PINMODE)  ? DATA_W'({pin_serial_mode_enable,
                                          15'h0000}) :
                                 23'h000000;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      err0       <= '0;
      err1       <= '0;
      mask       <= MASK_RST;
      sleep_flag <= 1'b0;
      rsp_addr   <= 8'h00;
      rsp_data   <= 23'h000000;
      frame_fault_summary_a <= 1'b1;
      frame_fault_summary_b <= 1'b1;
    end
    else
    begin
      err0 <= err_cond | (err0 & ~{ERR_W{rd_err0 | post}});
      err1 <= err_cond | (err1 & ~{ERR_W{rd_err1 | post}});
      sleep_flag <= sleep_exit | (sleep_flag & ~(rd_info | post));
      if (post)
        mask <= MASK_RST;
      else if (wr_mask)
        mask <= f_data[MASK_W-1:0];
      if (frame_done)
      begin
        rsp_addr <= f_addr;
        rsp_data <= rd_mux;
      end
      frame_fault_summary_a <= force_sum | cond_a
                               | (frame_fault_summary_a & ~rd_frame);
      frame_fault_summary_b <= force_sum | cond_b
                               | (frame_fault_summary_b & ~rd_frame);
    end
  end

  // ---------------------------------------------------------------
  // pin mode control
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_serial_mode_enable <= 1'b0;
      pwm_pin_out <= 1'b0;
      pwm_pin_oe  <= 1'b0;
      manch_rx    <= 1'b0;
    end
    else
    begin
      if (access_code_hit)
        pin_serial_mode_enable <= 1'b1;
      else if (post)
        pin_serial_mode_enable <= 1'b0;
      else if (wr_pin)
        pin_serial_mode_enable <= f_data[BIT_MANCH];
      pwm_pin_out <= pin_serial_mode_enable ? manch_tx_data
                                            : pwm_level;
      pwm_pin_oe  <= pin_serial_mode_enable ? manch_tx_oe : 1'b1;
      manch_rx    <= pin_serial_mode_enable & pin_s[1];
    end
  end

  // ---------------------------------------------------------------
  // pattern source, scan chains and compactors
  // ---------------------------------------------------------------
  logic [CHAIN_LEN-1:0] chain_a [SCAN_CHAINS];
  logic [CHAIN_LEN-1:0] chain_b [SCAN_CHAINS];
  logic [SIG_W-1:0]     out_a;
  logic [SIG_W-1:0]     out_b;
  for (genvar g = 0; g < SCAN_CHAINS; g++)
  begin : g_chain
    wire in_a = lfsr[g] ^ ((g == 0) & scan_fault_inject);
    always_ff @(posedge sys_clk or posedge rst)
    begin
      if (rst)
      begin
        chain_a[g] <= '0;
        chain_b[g] <= '0;
      end
      else if (run)
      begin
        chain_a[g] <= {chain_a[g][CHAIN_LEN-2:0], in_a};
        chain_b[g] <= {chain_b[g][CHAIN_LEN-2:0], lfsr[g]};
      end
    end
    assign out_a[g] = chain_a[g][CHAIN_LEN-1];
    assign out_b[g] = chain_b[g][CHAIN_LEN-1];
  end
  wire [SIG_W-1:0] next_lfsr = {lfsr[29:0], lfsr[30] ^ lfsr[27]};
  wire [SIG_W-1:0] next_signature_compactor_a =
      {signature_compactor_a[29:0], signature_compactor_a[30] ^ signature_compactor_a[27]} ^ out_a;
  wire [SIG_W-1:0] next_signature_compactor_b =
      {signature_compactor_b[29:0], signature_compactor_b[30] ^ signature_compactor_b[27]} ^ out_b;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      cnt   <= 32'h00000000;
      lfsr  <= LFSR_SEED;
      signature_compactor_a <= SIGNATURE_COMPACTOR_SEED;
      signature_compactor_b <= SIGNATURE_COMPACTOR_SEED;
      start_req <= 1'b0;
      done  <= 1'b0;
      pass  <= 1'b0;
      normal_op_hold <= 1'b0;
      full_rst_req   <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt   <= (next_state != state) ? 32'h00000000 : cnt + 32'h1;
      normal_op_hold <= (next_state != ST_IDLE);
      full_rst_req   <= (next_state == ST_POSTRST);
      if (start_req && !busy)
        start_req <= 1'b0;
      else if (wr_start)
        start_req <= 1'b1;
      if (start_req && !busy)
      begin
        lfsr   <= LFSR_SEED;
        signature_compactor_a <= SIGNATURE_COMPACTOR_SEED;
        signature_compactor_b <= SIGNATURE_COMPACTOR_SEED;
        done   <= 1'b0;
        pass   <= 1'b0;
      end
      else if (run)
      begin
        lfsr   <= next_lfsr;
        signature_compactor_a <= next_signature_compactor_a;
        signature_compactor_b <= next_signature_compactor_b;
        if (run_last)
        begin
          done <= 1'b1;
          pass <= sig_match;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_start_clears: assert property (@(posedge sys_clk) disable iff (rst)
    start_req && !busy |=> !start_req && run)
    else $error("start bit did not self clear into run");
  a_run_holds: assert property (@(posedge sys_clk) disable iff (rst)
    run && !run_last |=> run && normal_op_hold)
    else $error("test ended early");
  a_done_low_run: assert property (@(posedge sys_clk) disable iff (rst)
    run |-> !done)
    else $error("done high during test");
  a_pass_match: assert property (@(posedge sys_clk) disable iff (rst)
    run_last |=> done && (pass == $past(sig_match)))
    else $error("pass bit does not match signature");
  a_lfsr_live: assert property (@(posedge sys_clk) disable iff (rst)
    run |-> (lfsr != '0) && (next_lfsr != lfsr))
    else $error("pattern source stuck");
  a_post_reset: assert property (@(posedge sys_clk) disable iff (rst)
    run_last |=> full_rst_req [*8] ##[1:16] !full_rst_req && done)
    else $error("post test reset wrong");
  a_pin_manch: assert property (@(posedge sys_clk) disable iff (rst)
    pin_serial_mode_enable |=> pwm_pin_out == $past(manch_tx_data))
    else $error("pin not in serial mode");
  a_err_latch: assert property (@(posedge sys_clk) disable iff (rst)
    !rd_err0 && !post |=> (err0 & $past(err0)) == $past(err0))
    else $error("error flag lost without read");
  a_sum_force: assert property (@(posedge sys_clk) disable iff (rst)
    sleep_exit |=> frame_fault_summary_a && frame_fault_summary_b)
    else $error("summaries not forced");
  a_sum_set: assert property (@(posedge sys_clk) disable iff (rst)
    cond_a |=> frame_fault_summary_a)
    else $error("summary a missed a flag");
  a_busy_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    busy && $past(busy) |-> !spi_miso_oe && !frame_done)
    else $error("serial active during test");
  c_test_start: cover property (@(posedge sys_clk) disable iff (rst)
    start_req ##1 run);
  c_test_pass: cover property (@(posedge sys_clk) disable iff (rst)
    run_last ##1 pass);
  c_read_frame: cover property (@(posedge sys_clk) disable iff (rst)
    rd_err0);
  c_pin_mode: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(pin_serial_mode_enable));
endmodule
`default_nettype wire

//--- test/lstff_host.sv
`timescale 1ns/1ns
`default_nettype none
module lstff_host
  import lstff_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        spi_miso,
  input  wire logic        spi_miso_oe,
  output logic             spi_sclk,
  output logic             spi_cs_n,
  output logic             spi_mosi,
  output logic [31:0]      rsp_word,
  output logic             rsp_valid
);
  // ----------------------------------------
  // spi master, mode 0, sclk still between frames
  // ----------------------------------------
  logic seen;
  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    rsp_word = '0;
    rsp_valid = 1'b0;
    seen = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  // tests are launched over this link too
  task automatic xfer(input logic [31:0] tx);
    spi_cs_n = 1'b0;
    for (int i = FRAME_BITS - 1; i >= 0; i--)
    begin
      spi_mosi = tx[i];
      tick(4);
      spi_sclk = 1'b1;
      // undriven line: take the inverse of the last bit
      seen = spi_miso_oe ? spi_miso : ~seen;
      rsp_word[i] = seen;
      tick(4);
      spi_sclk = 1'b0;
    end
    tick(4);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    rsp_valid = 1'b1;
    tick(1);
    rsp_valid = 1'b0;
    tick(7);
  endtask
endmodule
`default_nettype wire

//--- test/lstff_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module lstff_top_bench;
  import lstff_pkg::*;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  localparam int TCYC = 600;
  localparam int LIMIT = 20000;
  logic sys_clk, rst, sclk, cs_n, mosi, miso, miso_oe, rv;
  logic [ERR_W-1:0] err_cond;
  logic [4:0] info;
  logic sleep_exit, code_hit, inj, pwm_level, tx_d, tx_oe, pin_ext;
  logic pin_out, pin_oe, mrx, mode, hold, frst, sa, sb;
  logic [31:0] rw, eq[$], mq[$], m, e;
  wire logic pin_wire;
  int bad_count, compares, seed, cyc, rlen, hlen, k;
  assign pin_wire = pin_oe ? pin_out : pin_ext;
  lstff_top #(.SELFTEST_CYC(TCYC), .CHAIN_LEN(CHAIN_LEN_DEF)) dut (
    .sys_clk(sys_clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
    .err_cond(err_cond), .angle_valid_flag(info[0]),
    .turn_direction_flag(info[1]), .encoder_countup_done(info[2]),
    .encoder_integrity_fault(info[3]), .edge_rate_warning(info[4]),
    .sleep_exit(sleep_exit), .access_code_hit(code_hit),
    .scan_fault_inject(inj), .pwm_level(pwm_level),
    .manch_tx_data(tx_d), .manch_tx_oe(tx_oe), .pwm_pin_in(pin_wire),
    .pwm_pin_out(pin_out), .pwm_pin_oe(pin_oe), .manch_rx(mrx),
    .pin_serial_mode_enable(mode), .normal_op_hold(hold),
    .full_rst_req(frst), .frame_fault_summary_a(sa),
    .frame_fault_summary_b(sb));
  lstff_host host (
    .sys_clk(sys_clk), .spi_miso(miso), .spi_miso_oe(miso_oe),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .rsp_word(rw), .rsp_valid(rv));
  always #25 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // response word expected in the frame after the one addressing a
  function automatic logic [31:0] r(logic s0, logic s1, logic [7:0] a,
                                    logic [21:0] d);
    return {s0, s1, a, d};
  endfunction
  task automatic frame(input logic [31:0] tx, input logic [31:0] mk,
                       input logic [31:0] ex);
    mq.push_back(mk);
    eq.push_back(ex);
    host.xfer(tx);
  endtask
  function automatic logic [31:0] rd(logic [7:0] a);
    return {1'b0, a, 23'h0};
  endfunction
  function automatic logic [31:0] wr(logic [7:0] a, logic [22:0] d);
    return {1'b1, a, d};
  endfunction
  always @(posedge sys_clk)
  begin
    cyc++;
    if (hold)
      hlen++;
    if (frst)
      rlen++;
    if (hold && miso_oe)
      check(miso_oe, 1'b0);
    if (rv && mq.size() > 0)
    begin
      m = mq.pop_front();
      e = eq.pop_front();
      check(rw & m, e & m);
    end
    if (cyc == LIMIT)
    begin
      bad_count++;
      final_report();
    end
  end
  initial
  begin
    {sys_clk, sleep_exit, code_hit, inj, pwm_level, tx_d, tx_oe} = '0;
    {pin_ext, err_cond, info} = '0;
    {bad_count, compares, cyc, rlen, hlen} = '0;
    seed = 34526;
    rst = 1'b1;
    host.tick(20);
    rst = 1'b0;
    host.tick(3);
    check(sa, 1);
    check(sb, 1);
    info = 5'($random(seed));
    frame(rd(REG_SELFTEST), 0, 0);
    frame(rd(REG_INFO), 32'h3fffffff, r(0, 0, REG_SELFTEST, 0));
    frame(rd(REG_INFO), 32'h3fffffff, r(0, 0, REG_INFO, 22'(info)));
    info = '0;
    sleep_exit = 1'b1;
    host.tick(1);
    sleep_exit = 1'b0;
    host.tick(2);
    check({sa, sb}, 2'b11);
    frame(rd(REG_INFO), 0, 0);
    frame(rd(REG_INFO), '1, r(0, 0, REG_INFO, 22'h40));
    $display("info and reset summary test done");
    k = $random(seed) & 15;
    err_cond[k] = 1'b1;
    host.tick(2);
    check({sa, sb}, 2'b11);
    frame(rd(REG_ERR0), '1, r(1, 1, REG_INFO, 0));
    err_cond = '0;
    frame(rd(REG_ERR1), '1, r(1, 1, REG_ERR0, 1 << k));
    frame(rd(REG_ERR0), 32'h3fffffff, r(0, 0, REG_ERR1, 1 << k));
    frame(rd(REG_ERR1), 32'h3fffffff, r(0, 0, REG_ERR0, 1 << k));
    frame(rd(REG_ERR0), '1, r(0, 0, REG_ERR1, 0));
    frame(wr(REG_MASK, 1 << k), '1, r(0, 0, REG_ERR0, 0));
    err_cond[k] = 1'b1;
    info[3] = 1'b1;
    host.tick(3);
    check(sa, 0);
    check(sb, 1);
    err_cond = '0;
    info = '0;
    frame(wr(REG_MASK, 0), 0, 0);
    $display("error flag test done");
    {pwm_level, tx_d, tx_oe, pin_ext} = 4'($random(seed));
    host.tick(2);
    check({pin_out, pin_oe}, {pwm_level, 1'b1});
    frame(wr(REG_PINMODE, 23'h8000), 0, 0);
    check(mode, 1);
    {pwm_level, tx_d, tx_oe, pin_ext} = 4'($random(seed));
    host.tick(4);
    check({pin_out, pin_oe, mrx}, {tx_d, tx_oe, tx_oe ? tx_d : pin_ext});
    frame(wr(REG_PINMODE, 0), 0, 0);
    check({mode, pin_out}, {1'b0, pwm_level});
    code_hit = 1'b1;
    host.tick(1);
    code_hit = 1'b0;
    host.tick(2);
    check(mode, 1);
    $display("pin mode test done");
    for (int t = 0; t < 2; t++)
    begin
      inj = t[0];
      {rlen, hlen} = '0;
      frame(wr(REG_SELFTEST, 1), 0, 0);
      frame(wr(REG_MASK, 23'h3ffff), 0, 0);
      for (int w = 0; w < 2000 && hold; w++)
        host.tick(1);
      check(rlen, POST_RST_CYCLES);
      check(hlen >= TCYC && hlen <= TCYC + POST_RST_CYCLES + 2, 1);
      check({sa, sb, mode}, 3'b110);
      frame(rd(REG_SELFTEST), 0, 0);
      frame(rd(REG_MASK), 32'h3fffffff, r(0, 0, REG_SELFTEST, {~inj, 2'b10}));
      frame(rd(REG_INFO), 32'h3fffffff, r(0, 0, REG_MASK, 0));
      $display("self test %0d done", t);
    end
    final_report();
  end
endmodule
`default_nettype wire
